// >>> hw/btd_comparator.sv
`timescale 1ns/1ps
`default_nettype none
module btd_comparator
  import btd_pkg::*;
#(
  parameter int ADDR_W = BTD_ADDR_W
) (
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [ADDR_W-1:0] i_value,
  input wire logic i_read,
  input wire logic i_dir_enable,
  input wire logic i_dir_value,
  output logic o_eq,
  output logic o_ge,
  output logic o_le
);

  logic dir_ok;

  // Direction value zero means writes only, one means reads only.
  assign dir_ok = !i_dir_enable || (i_read == i_dir_value); // [RULE12] [RULE13]
  // Full-width compare, evaluated once per bus cycle.
  assign o_eq = dir_ok && (i_addr == i_value); // [RULE24]
  assign o_ge = dir_ok && (i_addr >= i_value);
  assign o_le = dir_ok && (i_addr <= i_value);

endmodule : btd_comparator
`default_nettype wire

// >>> hw/btd_pkg.sv
package btd_pkg;

  // ----------------------------------------------------------------------
  // Register indices on the byte register port
  // ----------------------------------------------------------------------
  localparam logic [3:0] BTD_IDX_FORCE_RESET = 4'h0;
  localparam logic [3:0] BTD_IDX_CMP_A_HIGH = 4'h1;
  localparam logic [3:0] BTD_IDX_CMP_A_LOW = 4'h2;
  localparam logic [3:0] BTD_IDX_CMP_B_HIGH = 4'h3;
  localparam logic [3:0] BTD_IDX_CMP_B_LOW = 4'h4;
  localparam logic [3:0] BTD_IDX_FIFO_HIGH = 4'h5;
  localparam logic [3:0] BTD_IDX_FIFO_LOW = 4'h6;
  localparam logic [3:0] BTD_IDX_CONTROL = 4'h7;
  localparam logic [3:0] BTD_IDX_TRIGGER = 4'h8;
  localparam logic [3:0] BTD_IDX_STATUS = 4'h9;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BTD_FORCE_RESET_BIT = 0;
  localparam int BTD_CTL_MODULE_ON = 7;
  localparam int BTD_CTL_CAPTURE_GO = 6;
  localparam int BTD_CTL_TAG_SEL = 5;
  localparam int BTD_CTL_BREAK_EN = 4;
  localparam int BTD_CTL_A_DIR_VALUE = 3;
  localparam int BTD_CTL_A_DIR_ENABLE = 2;
  localparam int BTD_CTL_B_DIR_VALUE = 1;
  localparam int BTD_CTL_B_DIR_ENABLE = 0;
  localparam int BTD_TRG_QUALIFY_EXEC = 7;
  localparam int BTD_TRG_BEGIN = 6;
  localparam logic [7:0] BTD_TRG_WRITE_MASK = 8'hCF;

  // ----------------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------------
  localparam logic [7:0] BTD_BYTE_RESET = 8'h00;
  localparam int BTD_FIFO_DEPTH = 8;
  localparam int BTD_ADDR_W = 16;
  localparam logic [3:0] BTD_CNT_FULL = 4'h8;

  // ----------------------------------------------------------------------
  // Trigger mode codes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    BTD_M_A_ONLY = 4'h0,
    BTD_M_A_OR_B = 4'h1,
    BTD_M_A_THEN_B = 4'h2,
    BTD_M_EVENT_B = 4'h3,
    BTD_M_A_THEN_EVENT_B = 4'h4,
    BTD_M_A_AND_B_DATA = 4'h5,
    BTD_M_A_NOT_B_DATA = 4'h6,
    BTD_M_INSIDE = 4'h7,
    BTD_M_OUTSIDE = 4'h8
  } btd_mode_t;

endpackage : btd_pkg

// >>> hw/btd_trace_unit.sv
// How it works
// [RULE1] Force reset only from serial debug writes.
// [RULE2] Comparator bytes writable only while not armed.
// [RULE3] FIFO high byte reads zero in event modes.
// [RULE4] High read holds FIFO; low read advances.
// [RULE5] Event modes store data byte in low half.
// [RULE6] Low reads never advance FIFO while armed.
// [RULE7] Idle low read stores last fetch address.
// [RULE8] Module enable cannot set while secured.
// [RULE9] Capture go starts, completes or aborts run.
// [RULE10] Bit five picks tag or force break.
// [RULE11] Break at trigger or at FIFO full.
// [RULE12] Comparator A direction qualifies when enabled.
// [RULE13] Comparator B direction qualifies when enabled.
// [RULE14] Trigger register locked while armed; bits 4,5 zero.
// [RULE15] Qualify-exec compares executed opcode addresses.
// [RULE16] Begin bit picks begin or end trace.
// [RULE17] Nine trigger mode codes; others never trigger.
// [RULE18] Hit flags clear at arm, set on match.
// [RULE19] Status arm image; run completion conditions.
// [RULE20] Valid count clears at arm, never decrements.
// [RULE21] FIFO register writes have no effect.
// [RULE22] Event modes capture data on B matches.
// [RULE23] Break type output tells CPU tag or force.
// [RULE24] Full address compare per bus cycle.
`timescale 1ns/1ps
`default_nettype none
module btd_trace_unit
  import btd_pkg::*;
#(
  parameter int ADDR_W = BTD_ADDR_W,
  parameter int FIFO_DEPTH = BTD_FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_secure,
  input wire logic [3:0] i_reg_index,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_serial,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_bus_valid,
  input wire logic i_bus_read,
  input wire logic i_bus_fetch,
  input wire logic [ADDR_W-1:0] i_bus_addr,
  input wire logic [7:0] i_bus_data,
  input wire logic i_exec_valid,
  input wire logic [ADDR_W-1:0] i_exec_addr,
  output logic o_break_req,
  output logic o_break_tag,
  output logic o_force_reset
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The count field is four bits wide and the comparators are two bytes.
  if (FIFO_DEPTH != 8) begin : g_bad_depth
    $error("btd_trace_unit: FIFO_DEPTH must be 8");
  end
  if (ADDR_W != 16) begin : g_bad_width
    $error("btd_trace_unit: ADDR_W must be 16");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef logic [FIFO_DEPTH-1:0][ADDR_W-1:0] btd_fifo_t;

  typedef struct packed {
    logic [7:0] cmp_a_high;
    logic [7:0] cmp_a_low;
    logic [7:0] cmp_b_high;
    logic [7:0] cmp_b_low;
    logic [7:0] control;
    logic [7:0] trigger;
    logic a_hit;
    logic b_hit;
    logic a_seen;
    logic storing;
    logic [3:0] count;
    logic [ADDR_W-1:0] last_fetch;
    btd_fifo_t fifo;
    logic [7:0] rdata;
    logic break_req;
    logic break_tag;
    logic force_reset;
  } btd_state_t;

  btd_state_t s;
  btd_state_t next_s;

  // Slot zero is the read head; new words enter at the last slot.
  function automatic btd_fifo_t shift_in(input btd_fifo_t f, input logic [ADDR_W-1:0] w);
    btd_fifo_t r;
    r = f;
    for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
      r[i] = f[i+1];
    end
    r[FIFO_DEPTH-1] = w;
    return r;
  endfunction : shift_in

  function automatic logic is_event_mode(input logic [3:0] m);
    return (m == BTD_M_EVENT_B) || (m == BTD_M_A_THEN_EVENT_B);
  endfunction : is_event_mode

  // ----------------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------------
  logic qualify;
  logic cmp_valid;
  logic cmp_read;
  logic [ADDR_W-1:0] cmp_addr;
  logic [1:0] eq;
  logic [1:0] ge;
  logic [1:0] le;
  logic [1:0][ADDR_W-1:0] cmp_value;
  logic [1:0] dir_en;
  logic [1:0] dir_val;

  // Qualified triggers look at the executed opcode address instead of the
  // raw bus, so a prefetched but flushed opcode never fires.
  assign qualify = s.trigger[BTD_TRG_QUALIFY_EXEC];
  assign cmp_valid = qualify ? i_exec_valid : i_bus_valid; // [RULE15]
  assign cmp_addr = qualify ? i_exec_addr : i_bus_addr; // [RULE15]
  assign cmp_read = qualify ? 1'b1 : i_bus_read;
  assign cmp_value[0] = {s.cmp_a_high, s.cmp_a_low};
  assign cmp_value[1] = {s.cmp_b_high, s.cmp_b_low};
  assign dir_en = {s.control[BTD_CTL_B_DIR_ENABLE], s.control[BTD_CTL_A_DIR_ENABLE]};
  assign dir_val = {s.control[BTD_CTL_B_DIR_VALUE], s.control[BTD_CTL_A_DIR_VALUE]};

  for (genvar g = 0; g < 2; g++) begin : g_cmp
    btd_comparator #(
      .ADDR_W(ADDR_W)
    ) u_cmp (
      .i_addr(cmp_addr),
      .i_value(cmp_value[g]),
      .i_read(cmp_read),
      .i_dir_enable(dir_en[g]),
      .i_dir_value(dir_val[g]),
      .o_eq(eq[g]),
      .o_ge(ge[g]),
      .o_le(le[g])
    );
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic armed;
    logic match_a;
    logic match_b;
    logic data_b;
    logic hit;
    logic event_mode;
    logic begin_trace;
    logic capture;
    logic done;
    logic [ADDR_W-1:0] word;
    logic [7:0] new_ctl;
    logic [3:0] mode;
    armed = s.control[BTD_CTL_CAPTURE_GO];
    mode = s.trigger[3:0];
    match_a = cmp_valid && eq[0];
    match_b = cmp_valid && eq[1];
    data_b = i_bus_valid && (i_bus_data == s.cmp_b_low);
    hit = 1'b0;
    capture = 1'b0;
    done = 1'b0;
    word = i_bus_addr;
    new_ctl = i_reg_wdata;
    event_mode = is_event_mode(mode);
    begin_trace = s.trigger[BTD_TRG_BEGIN] || event_mode; // [RULE16]
    next_s = s;
    next_s.break_req = 1'b0;
    next_s.force_reset = 1'b0;
    next_s.break_tag = s.control[BTD_CTL_TAG_SEL]; // [RULE10] [RULE23]
    if (i_bus_valid && i_bus_fetch) begin
      next_s.last_fetch = i_bus_addr;
    end

    // Trigger decode.
    case (mode) // [RULE17]
      BTD_M_A_ONLY: hit = match_a;
      BTD_M_A_OR_B: hit = match_a || match_b;
      BTD_M_A_THEN_B: hit = s.a_seen && match_b;
      BTD_M_A_AND_B_DATA: hit = match_a && data_b;
      BTD_M_A_NOT_B_DATA: hit = match_a && i_bus_valid && !data_b;
      BTD_M_INSIDE: hit = cmp_valid && ge[0] && le[1];
      BTD_M_OUTSIDE: hit = cmp_valid && !(ge[0] && le[1]);
      default: hit = 1'b0;
    endcase

    // Capture run.
    if (armed) begin
      if (match_a) begin
        next_s.a_hit = 1'b1; // [RULE18]
        next_s.a_seen = 1'b1;
      end
      if (match_b) begin
        next_s.b_hit = 1'b1; // [RULE18]
      end
      if (event_mode) begin
        if (match_b && (mode == BTD_M_EVENT_B || s.a_seen)) begin // [RULE22]
          capture = 1'b1;
          word = {8'h00, i_bus_data}; // [RULE5]
        end
      end else if (begin_trace) begin
        if (hit) begin
          next_s.storing = 1'b1;
        end
        capture = s.storing && i_bus_valid && i_bus_fetch;
      end else begin
        capture = i_bus_valid && i_bus_fetch;
        if (hit) begin
          done = 1'b1; // [RULE19]
          next_s.break_req = s.control[BTD_CTL_BREAK_EN]; // [RULE11]
        end
      end
      if (capture) begin
        next_s.fifo = shift_in(s.fifo, word); // [RULE24]
        if (s.count != BTD_CNT_FULL) begin
          next_s.count = s.count + 4'h1; // [RULE20]
        end
        if (begin_trace && s.count == BTD_CNT_FULL - 4'h1) begin
          done = 1'b1; // [RULE19] [RULE22]
          next_s.break_req = s.control[BTD_CTL_BREAK_EN]; // [RULE11]
        end
      end
      if (done) begin
        next_s.control[BTD_CTL_CAPTURE_GO] = 1'b0; // [RULE9]
        next_s.storing = 1'b0;
      end
    end

    // Register writes; writes to the FIFO bytes fall through untouched.
    if (i_reg_wr) begin // [RULE21]
      if (i_reg_index == BTD_IDX_FORCE_RESET) begin
        next_s.force_reset = i_reg_serial && i_reg_wdata[BTD_FORCE_RESET_BIT]; // [RULE1]
      end else if (i_reg_index == BTD_IDX_CMP_A_HIGH && !armed) begin
        next_s.cmp_a_high = i_reg_wdata; // [RULE2]
      end else if (i_reg_index == BTD_IDX_CMP_A_LOW && !armed) begin
        next_s.cmp_a_low = i_reg_wdata; // [RULE2]
      end else if (i_reg_index == BTD_IDX_CMP_B_HIGH && !armed) begin
        next_s.cmp_b_high = i_reg_wdata; // [RULE2]
      end else if (i_reg_index == BTD_IDX_CMP_B_LOW && !armed) begin
        next_s.cmp_b_low = i_reg_wdata; // [RULE2]
      end else if (i_reg_index == BTD_IDX_TRIGGER && !armed) begin
        next_s.trigger = i_reg_wdata & BTD_TRG_WRITE_MASK; // [RULE14]
      end else if (i_reg_index == BTD_IDX_CONTROL) begin
        if (i_secure && !s.control[BTD_CTL_MODULE_ON]) begin
          new_ctl[BTD_CTL_MODULE_ON] = 1'b0; // [RULE8]
        end
        // Arming needs the module on; clearing either bit aborts the run.
        new_ctl[BTD_CTL_CAPTURE_GO] = i_reg_wdata[BTD_CTL_CAPTURE_GO] && new_ctl[BTD_CTL_MODULE_ON]; // [RULE9]
        next_s.control = new_ctl;
        if (new_ctl[BTD_CTL_CAPTURE_GO] && !armed) begin
          next_s.a_hit = 1'b0; // [RULE18]
          next_s.b_hit = 1'b0;
          next_s.a_seen = 1'b0;
          next_s.storing = 1'b0;
          next_s.count = 4'h0; // [RULE20]
        end else if (!new_ctl[BTD_CTL_CAPTURE_GO]) begin
          next_s.storing = 1'b0;
        end
      end
    end

    // Register reads, answered one cycle later.
    if (i_reg_rd) begin
      if (i_reg_index == BTD_IDX_CMP_A_HIGH) begin
        next_s.rdata = s.cmp_a_high;
      end else if (i_reg_index == BTD_IDX_CMP_A_LOW) begin
        next_s.rdata = s.cmp_a_low;
      end else if (i_reg_index == BTD_IDX_CMP_B_HIGH) begin
        next_s.rdata = s.cmp_b_high;
      end else if (i_reg_index == BTD_IDX_CMP_B_LOW) begin
        next_s.rdata = s.cmp_b_low;
      end else if (i_reg_index == BTD_IDX_FIFO_HIGH) begin
        next_s.rdata = event_mode ? BTD_BYTE_RESET : s.fifo[0][15:8]; // [RULE3] [RULE4]
      end else if (i_reg_index == BTD_IDX_FIFO_LOW) begin
        next_s.rdata = s.fifo[0][7:0];
        if (!armed) begin // [RULE6]
          next_s.fifo = shift_in(s.fifo, s.last_fetch); // [RULE4] [RULE7]
        end
      end else if (i_reg_index == BTD_IDX_CONTROL) begin
        next_s.rdata = s.control;
      end else if (i_reg_index == BTD_IDX_TRIGGER) begin
        next_s.rdata = s.trigger;
      end else if (i_reg_index == BTD_IDX_STATUS) begin
        next_s.rdata = {s.a_hit, s.b_hit, s.control[BTD_CTL_CAPTURE_GO] && s.control[BTD_CTL_MODULE_ON],
                        1'b0, s.count}; // [RULE19] [RULE20]
      end else begin
        next_s.rdata = BTD_BYTE_RESET; // [RULE1]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_reg_rdata = s.rdata;
  assign o_break_req = s.break_req;
  assign o_break_tag = s.break_tag;
  assign o_force_reset = s.force_reset;

endmodule : btd_trace_unit
`default_nettype wire

// >>> test/btd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module btd_cpu_model (
  input wire logic i_mclk,
  input wire logic i_run,
  input wire logic [15:0] i_base,
  output logic o_valid,
  output logic o_read,
  output logic o_fetch,
  output logic [15:0] o_addr,
  output logic [7:0] o_data,
  output logic o_exec_valid,
  output logic [15:0] o_exec_addr,
  output logic [15:0] o_last
);
  // ---------------------------------------------------------------
  // Fetch stream
  // ---------------------------------------------------------------
  // Fetches loop over four addresses so that matches repeat; idle lines toggle so no stale value looks valid.
  int k = 0;
  assign o_read = 1'b1;
  assign o_fetch = o_valid;
  initial begin
    o_valid = 1'b0;
    o_addr = 16'h0000;
    o_data = 8'h00;
    o_exec_valid = 1'b0;
    o_exec_addr = 16'h0000;
    o_last = 16'h0000;
  end
  always @(negedge i_mclk) begin
    o_exec_valid <= o_valid;
    o_exec_addr <= o_valid ? o_addr : ~o_exec_addr;
    if (i_run) begin
      o_valid <= 1'b1;
      o_addr <= i_base + 16'(k & 3);
      o_last <= i_base + 16'(k & 3);
      o_data <= 8'(k);
      k <= k + 1;
    end else begin
      o_valid <= 1'b0;
      o_addr <= ~o_addr;
      o_data <= ~o_data;
      k <= 0;
    end
  end
endmodule : btd_cpu_model
`default_nettype wire

// >>> test/btd_trace_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module btd_trace_unit_assertions
  import btd_pkg::*;
#(
  parameter int FIFO_DEPTH = BTD_FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_reg_index,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_serial,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_bus_valid,
  input wire logic i_exec_valid,
  input wire logic o_break_req,
  input wire logic o_force_reset
);
  // ---------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic fr_req;
  logic bus_any;
  assign fr_req = i_reg_wr && i_reg_serial && i_reg_index == BTD_IDX_FORCE_RESET;
  assign bus_any = i_bus_valid || i_exec_valid;
  a_reset_clean: assert property ($fell(i_sys_rst) |-> o_reg_rdata == 8'h00 && !o_break_req)
    else $error("outputs not clear after reset");
  a_force_serial: assert property (fr_req && i_reg_wdata[0] |=> o_force_reset)
    else $error("serial force reset write lost");
  a_force_cause: assert property (o_force_reset |-> $past(fr_req))
    else $error("force reset without serial write");
  a_force_read0: assert property (i_reg_rd && i_reg_index == BTD_IDX_FORCE_RESET |=> o_reg_rdata == 8'h00)
    else $error("force reset register read not zero");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_break_single: assert property (o_break_req |=> !o_break_req)
    else $error("break request longer than one cycle");
  a_break_cause: assert property (o_break_req |-> $past(bus_any))
    else $error("break request without bus activity");
  a_trg_fixed: assert property (i_reg_rd && i_reg_index == BTD_IDX_TRIGGER |=> o_reg_rdata[5:4] == 2'b00)
    else $error("trigger bits five and four not zero");
  a_count_range: assert property (i_reg_rd && i_reg_index == BTD_IDX_STATUS |=> o_reg_rdata[3:0] <= 4'(FIFO_DEPTH))
    else $error("valid count above depth");
endmodule : btd_trace_unit_assertions
bind btd_trace_unit btd_trace_unit_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_btd_trace_unit_assertions (
  .i_mclk, .i_sys_rst, .i_reg_index, .i_reg_wr, .i_reg_rd, .i_reg_serial, .i_reg_wdata,
  .o_reg_rdata, .i_bus_valid, .i_exec_valid, .o_break_req, .o_force_reset);
`default_nettype wire

// >>> test/test_btd_trace_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_btd_trace_unit;
  import btd_pkg::*;
  logic i_mclk = 0, i_sys_rst = 1, i_secure = 0, i_reg_wr = 0, i_reg_rd = 0, i_reg_serial = 0, run = 0;
  logic [3:0] i_reg_index = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata, i_bus_data, rv;
  logic [15:0] base = 16'h1040, i_bus_addr, i_exec_addr, last_fetch, exp_w;
  logic i_bus_valid, i_bus_read, i_bus_fetch, i_exec_valid, o_break_req, o_break_tag, o_force_reset, fr_seen;
  int miscompares = 0, cmp_count = 0, cycles = 0, i;
  logic [15:0] ref_q[$];
  initial forever #10 i_mclk = ~i_mclk;
  btd_trace_unit u_btd_trace_unit (.i_mclk, .i_sys_rst, .i_secure, .i_reg_index, .i_reg_wr, .i_reg_rd,
    .i_reg_serial, .i_reg_wdata, .o_reg_rdata, .i_bus_valid, .i_bus_read, .i_bus_fetch, .i_bus_addr,
    .i_bus_data, .i_exec_valid, .i_exec_addr, .o_break_req, .o_break_tag, .o_force_reset);
  btd_cpu_model u_btd_cpu_model (.i_mclk, .i_run(run), .i_base(base), .o_valid(i_bus_valid),
    .o_read(i_bus_read), .o_fetch(i_bus_fetch), .o_addr(i_bus_addr), .o_data(i_bus_data),
    .o_exec_valid(i_exec_valid), .o_exec_addr(i_exec_addr), .o_last(last_fetch));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic ser);
    @(negedge i_mclk);
    i_reg_index = idx;
    i_reg_wdata = d;
    i_reg_serial = ser;
    i_reg_wr = 1'b1;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
    fr_seen = o_force_reset;
  endtask : wr
  task automatic rd(input logic [3:0] idx);
    @(negedge i_mclk);
    i_reg_index = idx;
    i_reg_rd = 1'b1;
    @(negedge i_mclk);
    i_reg_rd = 1'b0;
    rv = o_reg_rdata;
  endtask : rd
  task automatic read_word(input logic hi_zero);
    exp_w = ref_q.pop_front();
    ref_q.push_back(last_fetch);
    rd(BTD_IDX_FIFO_HIGH);
    chk(rv, hi_zero ? 8'h00 : exp_w[15:8]);
    rd(BTD_IDX_FIFO_LOW);
    chk(rv, exp_w[7:0]);
  endtask : read_word
  task automatic wait_break(input logic tag);
    for (i = 0; i < 100 && o_break_req !== 1'b1; i++) @(negedge i_mclk);
    chk(16'(i < 100), 16'h0001);
    chk(o_break_tag, tag);
    run <= 1'b0;
    repeat (3) @(negedge i_mclk);
  endtask : wait_break
  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // The ceiling is dozens of times the length of the sequence below.
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    i = $urandom(32'h8692);
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    for (int r = 0; r < 16; r++) if (r != 6) begin
      rd(4'(r));
      chk(rv, 8'h00);
    end
    wr(BTD_IDX_FORCE_RESET, 8'h01, 1'b0);
    chk(fr_seen, 1'b0);
    wr(BTD_IDX_FORCE_RESET, 8'h01, 1'b1);
    chk(fr_seen, 1'b1);
    for (int r = 1; r < 5; r++) begin
      exp_w = 16'($urandom);
      wr(4'(r), exp_w[7:0], 1'b0);
      rd(4'(r));
      chk(rv, exp_w[7:0]);
    end
    for (int m = 0; m < 16; m++) begin
      wr(BTD_IDX_TRIGGER, 8'(m) | 8'h30, 1'b0);
      rd(BTD_IDX_TRIGGER);
      chk(rv, 8'(m));
    end
    i_secure = 1'b1;
    wr(BTD_IDX_CONTROL, 8'h80, 1'b0);
    rd(BTD_IDX_CONTROL);
    chk(rv, 8'h00);
    i_secure = 1'b0;
    base = {8'($urandom_range(8'hEF, 8'h10)), 8'h40};
    wr(BTD_IDX_CMP_A_HIGH, base[15:8], 1'b0);
    wr(BTD_IDX_CMP_A_LOW, 8'h43, 1'b0);
    wr(BTD_IDX_CMP_B_HIGH, base[15:8], 1'b0);
    wr(BTD_IDX_CMP_B_LOW, 8'h41, 1'b0);
    wr(BTD_IDX_TRIGGER, 8'h40, 1'b0);
    wr(BTD_IDX_CONTROL, 8'hD0, 1'b0);
    run <= 1'b1;
    wait_break(1'b0);
    rd(BTD_IDX_STATUS);
    chk(rv, 8'hC8);
    ref_q.delete();
    for (int r = 0; r < 8; r++) ref_q.push_back(base + 16'(r & 3));
    read_word(1'b0);
    wr(BTD_IDX_CONTROL, 8'hD4, 1'b0);
    rd(BTD_IDX_FIFO_LOW);
    chk(rv, ref_q[0][7:0]);
    rd(BTD_IDX_FIFO_LOW);
    chk(rv, ref_q[0][7:0]);
    wr(BTD_IDX_CMP_A_LOW, 8'h99, 1'b0);
    rd(BTD_IDX_CMP_A_LOW);
    chk(rv, 8'h43);
    wr(BTD_IDX_TRIGGER, 8'h02, 1'b0);
    rd(BTD_IDX_TRIGGER);
    chk(rv, 8'h40);
    run <= 1'b1;
    repeat (20) @(negedge i_mclk);
    rd(BTD_IDX_STATUS);
    chk(rv, 8'h60);
    run <= 1'b0;
    wr(BTD_IDX_CONTROL, 8'h80, 1'b0);
    rd(BTD_IDX_STATUS);
    chk(rv, 8'h40);
    repeat (8) read_word(1'b0);
    wr(BTD_IDX_TRIGGER, 8'h03, 1'b0);
    wr(BTD_IDX_CONTROL, 8'hF0, 1'b0);
    run <= 1'b1;
    wait_break(1'b1);
    rd(BTD_IDX_STATUS);
    chk(rv & 8'h7F, 8'h48);
    wr(BTD_IDX_FIFO_HIGH, 8'hFF, 1'b0);
    wr(BTD_IDX_FIFO_LOW, 8'hFF, 1'b0);
    ref_q.delete();
    for (int r = 0; r < 8; r++) ref_q.push_back(16'(1 + 4 * r));
    repeat (8) read_word(1'b1);
    // End trace on A only: four fetches up to and including the trigger are kept.
    wr(BTD_IDX_TRIGGER, 8'h00, 1'b0);
    wr(BTD_IDX_CONTROL, 8'hD0, 1'b0);
    run <= 1'b1;
    wait_break(1'b0);
    rd(BTD_IDX_STATUS);
    chk(rv, 8'hC4);
    give_verdict();
  end
endmodule : test_btd_trace_unit
`default_nettype wire
